// >>> core/gpc_params.svh
// Offsets, reset values and field positions of the two-port pin block
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH
`define GPC_ADDR_W       32
`define GPC_P0_MC_ADDR   32'h0ffff440
`define GPC_P0_PU_ADDR   32'h0ffffc40
`define GPC_P1_PU_ADDR   32'h0ffffc42
`define GPC_P0_DAT_ADDR  32'hfffff400
`define GPC_P1_DAT_ADDR  32'hfffff402
`define GPC_P0_DIR_ADDR  32'hfffff420
`define GPC_P1_DIR_ADDR  32'hfffff422
`define GPC_P1_MC_ADDR   32'hfffff442
`define GPC_P1_FS_ADDR   32'hfffff462
`define GPC_P1_FSE_ADDR  32'hfffff702
`define GPC_DIR_RST      8'hff
`define GPC_MC_RST       8'h00
`define GPC_PU_RST       8'h00
`define GPC_FS_RST       8'h00
`define GPC_LATCH_RST    8'h00
`define GPC_FSE_MASK     8'h07
`define GPC_MISSING_BIT  1
`define GPC_FILT_LEN     3
`endif

// >>> core/gpc_pkg.sv
// Types shared by the two-port pin block
package gpc_pkg;
  typedef struct packed
  {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpc_pad_t;

  typedef struct packed
  {
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } gpc_bus_t;

  typedef enum logic [1:0]
  {
    GPC_SEL_INV_OUT = 2'b00,
    GPC_SEL_CAPTURE = 2'b01,
    GPC_SEL_T2_OUT  = 2'b10,
    GPC_SEL_BAD     = 2'b11
  } gpc_sel_t;
endpackage

// >>> core/gpc_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module gpc_sync
(
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] async_i,
  output logic      [7:0] clean_o
);
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;

  // ==============================
  // Capture chain
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
    end
    else
    begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ==============================
  // Take change once stages two and three agree
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      clean_o <= 8'h00;
    else
      clean_o <= (s2 & s3) | (clean_o & (s2 | s3));
  end
endmodule

// >>> core/gpc_filter.sv
// Noise elimination: level must hold for a run of samples
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_filter
(
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] in_i,
  output logic      [7:0] filt_o
);
  genvar g;

  // ==============================
  // One run-length filter per pin
  generate
    for (g = 0; g < 8; g++)
    begin : g_bit
      logic [1:0] cnt;
      always_ff @(posedge core_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          cnt       <= 2'd0;
          filt_o[g] <= 1'b0;
        end
        else if (in_i[g] == filt_o[g])
          cnt <= 2'd0;
        else if (cnt == 2'(`GPC_FILT_LEN - 1))
        begin
          cnt       <= 2'd0;
          filt_o[g] <= in_i[g];
        end
        else
          cnt <= cnt + 2'd1;
      end
    end
  endgenerate
endmodule

// >>> core/gpc_port01.sv
// Port 0 and port 1 pin control with register file and alternate paths
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_port01
  import gpc_pkg::*;
#(
  parameter bit HAS_P0_PIN1 = 1'b1
)
(
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire gpc_pkg::gpc_bus_t bus_i,
  output logic            [7:0]  rdata_o,
  input  wire logic       [7:0]  p0_pin_i,
  input  wire logic       [7:0]  p1_pin_i,
  output gpc_pkg::gpc_pad_t      p0_pad_o,
  output gpc_pkg::gpc_pad_t      p1_pad_o,
  input  wire logic       [7:0]  p1_inv_out_i,
  input  wire logic       [2:0]  p1_t2_out_i,
  input  wire logic              hiz_req_i,
  input  wire logic              clk_stop_i,
  output logic            [7:0]  external_interrupt_input_o,
  output logic            [3:0]  shutoff_in_o,
  output logic            [1:0]  adc_trigger_in_o,
  output logic            [7:0]  p1_capture_in_o
);
  import gpc_pkg::*;

  logic [7:0] p0_latch;
  logic [7:0] p1_latch;
  logic [7:0] p0_dir;
  logic [7:0] p1_dir;
  logic [7:0] p0_mc;
  logic [7:0] p1_mc;
  logic [7:0] p0_pu;
  logic [7:0] p1_pu;
  logic [7:0] p1_fs;
  logic [7:0] p1_fse;
  logic [7:0] p0_sync;
  logic [7:0] p1_sync;
  logic [7:0] p0_filt;
  logic [7:0] p1_alt_oe;
  logic [7:0] p1_alt_out;
  logic [7:0] p1_alt_in;
  logic [7:0] next_rdata;
  logic       undef_bit;

  // ==============================
  // Address decode helper
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // ==============================
  // Pin input conditioning
  gpc_sync u_sync0
  (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    (p0_pin_i),
    .clean_o    (p0_sync)
  );

  gpc_sync u_sync1
  (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    (p1_pin_i),
    .clean_o    (p1_sync)
  );

  gpc_filter u_filt0
  (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .in_i       (p0_sync),
    .filt_o     (p0_filt)
  );

  // ==============================
  // Output latches
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p0_latch <= `GPC_LATCH_RST;
      p1_latch <= `GPC_LATCH_RST;
    end
    else if (bus_i.wr)
    begin
      if (hit(bus_i.addr, `GPC_P0_DAT_ADDR))
        p0_latch <= bus_i.wdata;
      if (hit(bus_i.addr, `GPC_P1_DAT_ADDR))
        p1_latch <= bus_i.wdata;
    end
  end

  // ==============================
  // Direction registers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p0_dir <= `GPC_DIR_RST;
      p1_dir <= `GPC_DIR_RST;
    end
    else if (bus_i.wr)
    begin
      if (hit(bus_i.addr, `GPC_P0_DIR_ADDR))
        p0_dir <= bus_i.wdata;
      if (hit(bus_i.addr, `GPC_P1_DIR_ADDR))
        p1_dir <= bus_i.wdata;
    end
  end

  // ==============================
  // Mode control registers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p0_mc <= `GPC_MC_RST;
      p1_mc <= `GPC_MC_RST;
    end
    else if (bus_i.wr)
    begin
      if (hit(bus_i.addr, `GPC_P0_MC_ADDR))
        p0_mc <= bus_i.wdata;
      if (hit(bus_i.addr, `GPC_P1_MC_ADDR))
        p1_mc <= bus_i.wdata;
    end
  end

  // ==============================
  // Pull-up registers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p0_pu <= `GPC_PU_RST;
      p1_pu <= `GPC_PU_RST;
    end
    else if (bus_i.wr)
    begin
      if (hit(bus_i.addr, `GPC_P0_PU_ADDR))
        p0_pu <= bus_i.wdata;
      if (hit(bus_i.addr, `GPC_P1_PU_ADDR))
        p1_pu <= bus_i.wdata;
    end
  end

  // ==============================
  // Function select registers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p1_fs  <= `GPC_FS_RST;
      p1_fse <= `GPC_FS_RST;
    end
    else if (bus_i.wr)
    begin
      if (hit(bus_i.addr, `GPC_P1_FS_ADDR))
        p1_fs <= bus_i.wdata;
      if (hit(bus_i.addr, `GPC_P1_FSE_ADDR))
        p1_fse <= bus_i.wdata & `GPC_FSE_MASK;
    end
  end

  // ==============================
  // Free-running bit for the absent pin
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      undef_bit <= 1'b0;
    else
      undef_bit <= ~undef_bit;
  end

  // ==============================
  // Read data mux
  always_comb
  begin
    next_rdata = 8'h00;
    if (hit(bus_i.addr, `GPC_P0_DAT_ADDR))
    begin
      next_rdata = (p0_dir & p0_sync) | (~p0_dir & p0_latch);
      if (!HAS_P0_PIN1)
        next_rdata[`GPC_MISSING_BIT] = undef_bit;
    end
    else if (hit(bus_i.addr, `GPC_P1_DAT_ADDR))
      next_rdata = (p1_dir & p1_sync) | (~p1_dir & p1_latch);
    else if (hit(bus_i.addr, `GPC_P0_DIR_ADDR))
      next_rdata = p0_dir;
    else if (hit(bus_i.addr, `GPC_P1_DIR_ADDR))
      next_rdata = p1_dir;
    else if (hit(bus_i.addr, `GPC_P0_MC_ADDR))
      next_rdata = p0_mc;
    else if (hit(bus_i.addr, `GPC_P1_MC_ADDR))
      next_rdata = p1_mc;
    else if (hit(bus_i.addr, `GPC_P0_PU_ADDR))
      next_rdata = p0_pu;
    else if (hit(bus_i.addr, `GPC_P1_PU_ADDR))
      next_rdata = p1_pu;
    else if (hit(bus_i.addr, `GPC_P1_FS_ADDR))
      next_rdata = p1_fs;
    else if (hit(bus_i.addr, `GPC_P1_FSE_ADDR))
      next_rdata = p1_fse;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 8'h00;
    else if (bus_i.rd)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end

  // ==============================
  // Port 1 alternate function select
  always_comb
  begin
    p1_alt_oe  = 8'h00;
    p1_alt_out = 8'h00;
    p1_alt_in  = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (i < 3)
      begin
        case (gpc_sel_t'({p1_fse[i], p1_fs[i]}))
          GPC_SEL_INV_OUT:
          begin
            p1_alt_oe[i]  = 1'b1;
            p1_alt_out[i] = p1_inv_out_i[i];
          end
          GPC_SEL_T2_OUT:
          begin
            p1_alt_oe[i]  = 1'b1;
            p1_alt_out[i] = p1_t2_out_i[i];
          end
          GPC_SEL_CAPTURE:
          begin
            p1_alt_oe[i]  = 1'b0;
            p1_alt_out[i] = 1'b0;
            p1_alt_in[i]  = 1'b1;
          end
          default:
          begin
            p1_alt_oe[i]  = 1'b0;
            p1_alt_out[i] = 1'b0;
          end
        endcase
      end
      else
      begin
        p1_alt_oe[i]  = ~p1_fs[i];
        p1_alt_out[i] = p1_inv_out_i[i];
        p1_alt_in[i]  = p1_fs[i];
      end
      // Motor outputs released on shutoff, pin 6 excluded
      if (i != 6 && (hiz_req_i || clk_stop_i))
        p1_alt_oe[i] = 1'b0;
    end
  end

  // ==============================
  // Pad drive
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      p0_pad_o <= '0;
      p1_pad_o <= '0;
    end
    else
    begin
      p0_pad_o.out <= p0_latch;
      p0_pad_o.oe  <= ~p0_mc & ~p0_dir;
      p0_pad_o.pu  <= p0_pu & (p0_dir | p0_mc);
      p1_pad_o.out <= (p1_mc & p1_alt_out) | (~p1_mc & p1_latch);
      p1_pad_o.oe  <= (p1_mc & p1_alt_oe) | (~p1_mc & ~p1_dir);
      p1_pad_o.pu  <= p1_pu & ((~p1_mc & p1_dir) | (p1_mc & ~p1_alt_oe));
    end
  end

  // ==============================
  // Alternate input routing
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      external_interrupt_input_o <= 8'h00;
      shutoff_in_o               <= 4'h0;
      adc_trigger_in_o           <= 2'b00;
      p1_capture_in_o            <= 8'h00;
    end
    else
    begin
      external_interrupt_input_o <= p0_mc & p0_filt;
      shutoff_in_o               <= p0_mc[3:0] & p0_filt[3:0];
      adc_trigger_in_o           <= p0_mc[5:4] & p0_filt[5:4];
      p1_capture_in_o            <= p1_mc & p1_alt_in & p1_sync;
    end
  end

  // ==============================
  // Checks
  AST_DIR_RESET: assert property (@(posedge core_clk_i)
    $rose(nrst_i) |-> p0_pad_o.oe == 8'h00) else $error("pins not input after reset");

  AST_P0_OUT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 (p0_pad_o.out == $past(p0_latch))) else $error("p0 pin level wrong");

  AST_PORT_OE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ##1 (p0_pad_o.oe == $past(~p0_mc & ~p0_dir))) else $error("p0 drive wrong");

  AST_PU_NOT_OUT: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (p0_pad_o.pu & p0_pad_o.oe) == 8'h00) else $error("pull-up on output");

  AST_SHUTOFF: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (hiz_req_i || clk_stop_i) |=> (p1_pad_o.oe & $past(p1_mc) & 8'hbf) == 8'h00)
    else $error("motor output not released");

  AST_READ_LATCH: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (bus_i.rd && hit(bus_i.addr, `GPC_P1_DAT_ADDR) && p1_dir == 8'h00)
    |=> rdata_o == $past(p1_latch)) else $error("read of latch wrong");

  AST_MC_RESET: assert property (@(posedge core_clk_i)
    $rose(nrst_i) |-> p1_mc == 8'h00 && p0_mc == 8'h00) else $error("mode bits not clear");

  AST_INT_ROUTE: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (p0_mc == 8'h00) |=> external_interrupt_input_o == 8'h00)
    else $error("interrupt routed in port mode");

  AST_SEL_CAP: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (p1_mc[0] && !p1_fse[0] && p1_fs[0]) |=> !p1_pad_o.oe[0]) else $error("capture driven");

  AST_FS_HI: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (p1_mc[4] && p1_fs[4]) |=> !p1_pad_o.oe[4]) else $error("input function driven");
endmodule

// >>> tb/gpc_pin_model.sv
// Pin-side model: resolves pad drive, outside drive and pull-up
`timescale 1ns/1ps
module gpc_pin_model
  import gpc_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire gpc_pkg::gpc_pad_t pad_i,
  input  wire logic        [7:0] ext_lvl_i,
  input  wire logic        [7:0] ext_en_i,
  output logic             [7:0] pin_o
);
  logic [7:0] float_q = 8'h55;

  // ====================================
  // Undriven pins wander every cycle
  always_ff @(posedge core_clk_i)
    float_q <= ~float_q;

  // ====================================
  // Pad drive first, then outside, then pull-up
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad_i.oe[i])
        pin_o[i] = pad_i.out[i];
      else if (ext_en_i[i])
        pin_o[i] = ext_lvl_i[i];
      else if (pad_i.pu[i])
        pin_o[i] = 1'b1;
      else
        pin_o[i] = float_q[i];
    end
  end
endmodule

// >>> tb/gpc_port01_tb.sv
// Self-checking bench for the two-port pin block
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_port01_tb;
  import gpc_pkg::*;
  logic       core_clk_i;
  logic       nrst_i;
  gpc_bus_t   bus;
  gpc_pad_t   pad0;
  gpc_pad_t   pad1;
  logic [7:0] rdata;
  logic [7:0] p0_pin;
  logic [7:0] p1_pin;
  logic [7:0] inv;
  logic [7:0] ev0;
  logic [7:0] ee0;
  logic [7:0] ev1;
  logic [7:0] ee1;
  logic [7:0] eii;
  logic [7:0] cap;
  logic [3:0] shut;
  logic [1:0] adc;
  logic [2:0] t2;
  logic       hiz;
  logic       cstop;
  int         n_errors;
  int         samples_checked;

  gpc_port01 #(.HAS_P0_PIN1(1'b1)) u_dut
  (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata),
    .p0_pin_i(p0_pin), .p1_pin_i(p1_pin), .p0_pad_o(pad0), .p1_pad_o(pad1),
    .p1_inv_out_i(inv), .p1_t2_out_i(t2), .hiz_req_i(hiz), .clk_stop_i(cstop),
    .external_interrupt_input_o(eii), .shutoff_in_o(shut),
    .adc_trigger_in_o(adc), .p1_capture_in_o(cap)
  );
  gpc_pin_model u_pin0
  (
    .core_clk_i(core_clk_i), .pad_i(pad0), .ext_lvl_i(ev0), .ext_en_i(ee0), .pin_o(p0_pin)
  );
  gpc_pin_model u_pin1
  (
    .core_clk_i(core_clk_i), .pad_i(pad1), .ext_lvl_i(ev1), .ext_en_i(ee1), .pin_o(p1_pin)
  );

  // ====================================
  // Clock and helpers
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic end_sim();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #40000;
    n_errors++;
    end_sim();
  end

  // ====================================
  // Test sequence
  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    nrst_i = 1'b0;
    bus = '0;
    {ev0, ee0, ev1, ee1, inv} = '0;
    {t2, hiz, cstop} = '0;
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    cyc(1);
    chk(pad1.oe, 8'h00);
    rd(`GPC_P0_DIR_ADDR, `GPC_DIR_RST);
    rd(`GPC_P1_DIR_ADDR, 8'hff);
    rd(`GPC_P0_MC_ADDR, 8'h00);
    rd(`GPC_P1_MC_ADDR, 8'h00);
    rd(`GPC_P0_PU_ADDR, 8'h00);
    rd(`GPC_P1_PU_ADDR, 8'h00);
    rd(`GPC_P1_FS_ADDR, 8'h00);
    rd(`GPC_P1_FSE_ADDR, 8'h00);
    // Port 1 plain outputs, then per-pin mix
    wr(`GPC_P1_DIR_ADDR, 8'h00);
    wr(`GPC_P1_DAT_ADDR, 8'ha5);
    wr(`GPC_P1_PU_ADDR, 8'h0f);
    cyc(3);
    chk(pad1.out, 8'ha5);
    chk(pad1.oe, 8'hff);
    chk(pad1.pu, 8'h00);
    rd(`GPC_P1_DAT_ADDR, 8'ha5);
    ee1 <= 8'hff;
    ev1 <= 8'h5a;
    wr(`GPC_P1_DIR_ADDR, 8'h3c);
    cyc(8);
    chk(pad1.oe, 8'hc3);
    chk(pad1.pu, 8'h0c);
    rd(`GPC_P1_DAT_ADDR, 8'h99);
    wr(`GPC_P1_DAT_ADDR, 8'h81);
    wr(`GPC_P1_DIR_ADDR, 8'h00);
    cyc(3);
    chk(pad1.out, 8'h81);
    // Port 0 port mode, then alternate inputs through the filter
    wr(`GPC_P0_DIR_ADDR, 8'h0f);
    wr(`GPC_P0_DAT_ADDR, 8'h3c);
    wr(`GPC_P0_PU_ADDR, 8'hff);
    cyc(3);
    chk(pad0.oe, 8'hf0);
    chk(pad0.out & 8'hf0, 8'h30);
    chk(pad0.pu, 8'h0f);
    ee0 <= 8'hf0;
    ev0 <= 8'h30;
    wr(`GPC_P0_MC_ADDR, 8'hff);
    cyc(12);
    chk(pad0.oe, 8'h00);
    chk(pad0.pu, 8'hff);
    chk(eii, 8'h3f);
    chk({4'h0, shut}, 8'h0f);
    chk({6'h00, adc}, 8'h03);
    ev0 <= 8'h00;
    cyc(12);
    chk(eii, 8'h0f);
    ev0 <= 8'hf0;
    cyc(2);
    ev0 <= 8'h00;
    cyc(12);
    chk(eii, 8'h0f);
    ev0 <= 8'h20;
    wr(`GPC_P0_MC_ADDR, 8'h30);
    cyc(12);
    chk(eii, 8'h20);
    chk({4'h0, shut}, 8'h00);
    chk({6'h00, adc}, 8'h02);
    wr(`GPC_P0_MC_ADDR, 8'h00);
    // Port 1 alternate functions
    inv <= 8'ha5;
    t2 <= 3'b010;
    wr(`GPC_P1_PU_ADDR, 8'hff);
    wr(`GPC_P1_FS_ADDR, 8'h00);
    wr(`GPC_P1_MC_ADDR, 8'hff);
    cyc(3);
    chk(pad1.out, 8'ha5);
    chk(pad1.oe, 8'hff);
    chk(pad1.pu, 8'h00);
    wr(`GPC_P1_FSE_ADDR, 8'h07);
    cyc(3);
    chk(pad1.out, 8'ha2);
    wr(`GPC_P1_FSE_ADDR, 8'h00);
    wr(`GPC_P1_FS_ADDR, 8'hff);
    cyc(8);
    chk(pad1.oe, 8'h00);
    chk(pad1.pu, 8'hff);
    chk(cap, 8'h5a);
    wr(`GPC_P1_FSE_ADDR, 8'hff);
    wr(`GPC_P1_FS_ADDR, 8'h07);
    cyc(8);
    rd(`GPC_P1_FSE_ADDR, 8'h07);
    chk(pad1.oe, 8'hf8);
    chk(cap, 8'h00);
    // Motor outputs released by shutoff and clock stop
    wr(`GPC_P1_FS_ADDR, 8'h00);
    wr(`GPC_P1_FSE_ADDR, 8'h00);
    hiz <= 1'b1;
    cyc(3);
    chk(pad1.oe, 8'h40);
    chk(pad1.pu, 8'hbf);
    chk(cap, 8'h00);
    hiz <= 1'b0;
    cstop <= 1'b1;
    cyc(3);
    chk(pad1.oe, 8'h40);
    cstop <= 1'b0;
    cyc(3);
    chk(pad1.oe, 8'hff);
    // Unmapped place
    wr(32'hfffff404, 8'hff);
    rd(32'hfffff404, 8'h00);
    end_sim();
  end
endmodule
